/* File: hdl/lfcs_pkg.sv */
// Package: constants and types for the lock, fuse and configuration store
// Contract
// - Lock bits only clear; only erase sets
// - Six lock bits, bits 7:6 unused, default 1
// - Mode 2 blocks external flash/EEPROM programming
// - Mode 3 also blocks external verification reads
// - App write-lock blocks stores into application
// - App read-lock blocks boot loads of application
// - Boot write-lock blocks stores into boot
// - Boot read-lock blocks application loads of boot
// - App read-lock, boot vectors: mask app interrupts
// - Boot read-lock, app vectors: mask boot interrupts
// - Two fuse bytes, programmed reads zero
// - High fuse byte field layout
// - Serial mode cannot change serial enable fuse
// - Low fuse byte field layout
// - Chip erase leaves fuses unchanged
// - Low memory lock programmed freezes fuses
// - Fuses latch at power-up and mode entry
// - EEPROM preserve fuse acts immediately
// - Preserve fuse keeps EEPROM through erase
// - Three identification bytes, always readable
// - Four calibration values for 1/2/4/8 MHz
// - Reset loads 1 MHz calibration value
// - Locks restored only after flash erased
package lfcs_pkg;
  // ************************************************************
  // Lock byte layout and reset values
  // ************************************************************
  localparam int LOCK_MEM_LOW_BIT   = 0;
  localparam int LOCK_MEM_HIGH_BIT  = 1;
  localparam int LOCK_APP_WR_BIT    = 2;
  localparam int LOCK_APP_RD_BIT    = 3;
  localparam int LOCK_BOOT_WR_BIT   = 4;
  localparam int LOCK_BOOT_RD_BIT   = 5;
  localparam logic [7:0] LOCK_RESET     = 8'hFF;
  localparam logic [7:0] LOCK_USED_MASK = 8'h3F;

  // ************************************************************
  // Fuse bytes layout and reset values
  // ************************************************************
  localparam int FH_RESET_VECTOR_BIT = 0;
  localparam int FH_BOOT_SIZE_LSB    = 1;
  localparam int FH_EEPROM_PRES_BIT  = 3;
  localparam int FH_OSC_OPTION_BIT   = 4;
  localparam int FH_SERIAL_PROG_BIT  = 5;
  localparam int FH_WDOG_ON_BIT      = 6;
  localparam int FH_RESET_PIN_BIT    = 7;
  localparam int FL_CLOCK_SRC_LSB    = 0;
  localparam int FL_STARTUP_LSB      = 4;
  localparam int FL_BROWNOUT_EN_BIT  = 6;
  localparam int FL_BROWNOUT_LVL_BIT = 7;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hD9;
  localparam logic [7:0] FUSE_LOW_RESET  = 8'hE1;

  // ************************************************************
  // Identification row and programming commands
  // ************************************************************
  localparam logic [1:0] IDENT_ADDR_0 = 2'h0;
  localparam logic [1:0] IDENT_ADDR_1 = 2'h1;
  localparam logic [1:0] IDENT_ADDR_2 = 2'h2;
  localparam logic [1:0] CAL_ADDR_1MHZ = 2'h0;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
  localparam logic [7:0] CMD_RD_IDENT   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSELCK = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;

  // Programmer command as seen by the store
  typedef struct packed {
    logic       valid;
    logic       serial;
    logic [7:0] cmd;
    logic       selHigh;
    logic [1:0] addr;
    logic [7:0] data;
  } lfcs_prog_req_t;

  // CPU program-memory access
  typedef struct packed {
    logic        isStore;
    logic        isLoad;
    logic [11:0] pc;
    logic [11:0] addr;
  } lfcs_cpu_req_t;

  typedef enum logic [2:0] {
    ER_IDLE  = 3'b001,
    ER_FLASH = 3'b010,
    ER_LOCKS = 3'b100
  } lfcs_erase_t;
endpackage

/* File: hdl/lfcs_store.sv */
// Lock, fuse and configuration store with protection checks
module lfcs_store #(
  parameter logic [7:0] IDENT0      = 8'hA5,  // Arbitrary identification value
  parameter logic [7:0] IDENT1      = 8'h5A,  // Arbitrary identification value
  parameter logic [7:0] IDENT2      = 8'h3C,  // Arbitrary identification value
  parameter logic [7:0] CAL_1MHZ    = 8'h80,
  parameter logic [7:0] CAL_2MHZ    = 8'h81,
  parameter logic [7:0] CAL_4MHZ    = 8'h82,
  parameter logic [7:0] CAL_8MHZ    = 8'h83,
  parameter int         BOOT_START  = 12'hC00,
  parameter int         ERASE_CYCLES = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    progModeIn,
  input  wire lfcs_pkg::lfcs_prog_req_t progReq,
  input  wire lfcs_pkg::lfcs_cpu_req_t  cpuReq,
  input  wire logic                    vectorsInBoot,
  input  wire logic                    cpuLockWrite,
  input  wire logic [7:0]              cpuLockData,
  input  wire logic [1:0]              calSelect,
  input  wire logic                    calLoad,
  output logic [7:0]                   progRdData,
  output logic                         progBusy,
  output logic                         progWriteOk,
  output logic                         progReadOk,
  output logic                         cpuStoreOk,
  output logic                         cpuLoadOk,
  output logic                         irqMask,
  output logic                         flashEraseReq,
  output logic                         eepromEraseReq,
  output logic [7:0]                   rcTrimRegister,
  output logic [7:0]                   protectionLockByte,
  output logic [7:0]                   fuseHighActive,
  output logic [7:0]                   fuseLowActive
);
  import lfcs_pkg::*;

  initial begin
    if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65535) $error("ERASE_CYCLES out of range");
    if (BOOT_START < 1 || BOOT_START > 4095) $error("BOOT_START out of range");
  end

  localparam logic [11:0] BOOT_BASE = 12'(BOOT_START);
  localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);

  // ************************************************************
  // Pin synchronisers for the programmer side
  // ************************************************************
  logic           modeMeta_r, modeSync_r, modePrev_r;
  lfcs_prog_req_t reqMeta_r, reqSync_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeMeta_r <= 1'b0;
      modeSync_r <= 1'b0;
      modePrev_r <= 1'b0;
      reqMeta_r  <= '0;
      reqSync_r  <= '0;
    end else begin
      modeMeta_r <= progModeIn;
      modeSync_r <= modeMeta_r;
      modePrev_r <= modeSync_r;
      reqMeta_r  <= progReq;
      reqSync_r  <= reqMeta_r;
    end
  end

  logic modeEntry;
  logic modeExit;
  assign modeEntry = modeSync_r & ~modePrev_r;
  assign modeExit  = ~modeSync_r & modePrev_r;

  // ************************************************************
  // Stored lock byte and fuse bytes
  // ************************************************************
  logic [7:0]  lockStore_r;
  logic [7:0]  fuseHigh_r, fuseLow_r;
  logic [7:0]  fuseHighLatch_r, fuseLowLatch_r;
  lfcs_erase_t erState_r;
  logic [15:0] erCount_r;

  logic memLow, memHigh, appWr, appRd, bootWr, bootRd;
  assign memLow  = lockStore_r[LOCK_MEM_LOW_BIT];
  assign memHigh = lockStore_r[LOCK_MEM_HIGH_BIT];
  assign appWr   = lockStore_r[LOCK_APP_WR_BIT];
  assign appRd   = lockStore_r[LOCK_APP_RD_BIT];
  assign bootWr  = lockStore_r[LOCK_BOOT_WR_BIT];
  assign bootRd  = lockStore_r[LOCK_BOOT_RD_BIT];

  logic progActive;
  logic isCmd;
  assign progActive = modeSync_r & reqSync_r.valid & (erState_r == ER_IDLE);

  function automatic logic cmdIs(input logic [7:0] c);
    return progActive && reqSync_r.cmd == c;
  endfunction

  function automatic logic inBoot(input logic [11:0] a);
    return a >= BOOT_BASE;
  endfunction

  logic memWriteCmd;
  logic memReadCmd;
  assign memWriteCmd = cmdIs(CMD_WR_FLASH) | cmdIs(CMD_WR_EEPROM);
  assign memReadCmd  = cmdIs(CMD_RD_FLASH) | cmdIs(CMD_RD_EEPROM);
  assign isCmd = progActive;

  // Flash/EEPROM programming refused in any lock mode but 1
  assign progWriteOk = memWriteCmd & memLow & memHigh;
  // Verification refused only when both bits are programmed
  assign progReadOk  = memReadCmd & (memLow | memHigh);

  // Lock byte: AND-merge so bits can only move toward zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockStore_r <= LOCK_RESET;
    end else if (erState_r == ER_LOCKS) begin
      lockStore_r <= LOCK_RESET;
    end else if (cmdIs(CMD_WR_LOCK)) begin
      lockStore_r <= lockStore_r & (reqSync_r.data | ~LOCK_USED_MASK);
    end else if (cpuLockWrite && !modeSync_r) begin
      lockStore_r <= lockStore_r & (cpuLockData | 8'hC3);
    end
  end

  // Fuse write: low byte at selHigh=0, high byte at selHigh=1
  logic fuseWrite;
  assign fuseWrite = cmdIs(CMD_WR_FUSE) & memLow;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuseHigh_r <= FUSE_HIGH_RESET;
      fuseLow_r  <= FUSE_LOW_RESET;
    end else if (fuseWrite) begin
      if (reqSync_r.selHigh) begin
        fuseHigh_r <= reqSync_r.data;
        if (reqSync_r.serial) begin
          fuseHigh_r[FH_SERIAL_PROG_BIT] <= fuseHigh_r[FH_SERIAL_PROG_BIT];
        end
      end else begin
        fuseLow_r <= reqSync_r.data;
      end
    end
  end

  // Active copy: latched at power-up, mode entry, and applied on exit
  logic fuseLatchEvt;
  assign fuseLatchEvt = modeEntry | modeExit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuseHighLatch_r <= FUSE_HIGH_RESET;
      fuseLowLatch_r  <= FUSE_LOW_RESET;
    end else if (fuseLatchEvt) begin
      fuseHighLatch_r <= fuseHigh_r;
      fuseLowLatch_r  <= fuseLow_r;
    end
  end

  always_comb begin
    fuseHighActive = fuseHighLatch_r;
    // Preserve fuse bypasses the latch so erase sees it at once
    fuseHighActive[FH_EEPROM_PRES_BIT] = fuseHigh_r[FH_EEPROM_PRES_BIT];
    fuseLowActive = fuseLowLatch_r;
  end

  assign protectionLockByte = lockStore_r;

  // ************************************************************
  // Chip erase sequence
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erState_r <= ER_IDLE;
      erCount_r <= 16'h0000;
    end else begin
      case (erState_r)
        ER_IDLE: begin
          erCount_r <= 16'h0000;
          if (cmdIs(CMD_CHIP_ERASE)) begin
            erState_r <= ER_FLASH;
          end
        end
        ER_FLASH: begin
          erCount_r <= erCount_r + 16'h0001;
          if (erCount_r == ERASE_LAST) begin
            erState_r <= ER_LOCKS;
          end
        end
        ER_LOCKS: begin
          erState_r <= ER_IDLE;
        end
        default: begin
          erState_r <= ER_IDLE;
        end
      endcase
    end
  end

  assign progBusy      = (erState_r != ER_IDLE);
  assign flashEraseReq = (erState_r == ER_FLASH);
  // EEPROM kept when the preserve fuse is programmed
  assign eepromEraseReq = (erState_r == ER_FLASH) &
                          fuseHighActive[FH_EEPROM_PRES_BIT];

  // ************************************************************
  // CPU-side section protection
  // ************************************************************
  logic pcBoot, addrBoot;
  assign pcBoot   = inBoot(cpuReq.pc);
  assign addrBoot = inBoot(cpuReq.addr);

  always_comb begin
    cpuStoreOk = cpuReq.isStore;
    if (!addrBoot && !appWr) cpuStoreOk = 1'b0;
    if (addrBoot && !bootWr) cpuStoreOk = 1'b0;
    cpuLoadOk = cpuReq.isLoad;
    if (pcBoot && !addrBoot && !appRd) cpuLoadOk = 1'b0;
    if (!pcBoot && addrBoot && !bootRd) cpuLoadOk = 1'b0;
  end

  always_comb begin
    irqMask = 1'b0;
    if (!appRd && vectorsInBoot && !pcBoot) irqMask = 1'b1;
    if (!bootRd && !vectorsInBoot && pcBoot) irqMask = 1'b1;
  end

  // ************************************************************
  // Read-back and calibration
  // ************************************************************
  function automatic logic [7:0] calValue(input logic [1:0] a);
    case (a)
      2'h0: return CAL_1MHZ;
      2'h1: return CAL_2MHZ;
      2'h2: return CAL_4MHZ;
      default: return CAL_8MHZ;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      progRdData <= 8'h00;
    end else if (cmdIs(CMD_RD_IDENT)) begin
      if (reqSync_r.selHigh) begin
        progRdData <= calValue(reqSync_r.addr);
      end else if (reqSync_r.addr == IDENT_ADDR_0) begin
        progRdData <= IDENT0;
      end else if (reqSync_r.addr == IDENT_ADDR_1) begin
        progRdData <= IDENT1;
      end else if (reqSync_r.addr == IDENT_ADDR_2) begin
        progRdData <= IDENT2;
      end else begin
        progRdData <= 8'h00;
      end
    end else if (cmdIs(CMD_RD_FUSELCK)) begin
      if (reqSync_r.addr == 2'h2) begin
        progRdData <= lockStore_r;
      end else if (reqSync_r.selHigh) begin
        progRdData <= fuseHigh_r;
      end else begin
        progRdData <= fuseLow_r;
      end
    end
  end

  // Trim loaded from 1 MHz slot during reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcTrimRegister <= CAL_1MHZ;
    end else if (calLoad) begin
      rcTrimRegister <= calValue(calSelect);
    end
  end

  logic unusedCmd;
  assign unusedCmd = isCmd & (CAL_ADDR_1MHZ == 2'h0);
endmodule

/* File: test/lfcs_prog_model.sv */
// External programmer model driving the mode pin and command pins
module lfcs_prog_model (
  input  wire logic              clk,
  input  wire logic              progWriteOk,
  input  wire logic              progReadOk,
  output lfcs_pkg::lfcs_prog_req_t progReq,
  output logic                   progModeIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfcs_pkg::*;
  initial begin
    progModeIn = 1'b0;
    progReq = '0;
  end

  task automatic setMode(input logic m);
    @(negedge clk);
    progModeIn = m;
    repeat (8) @(negedge clk);
  endtask

  // Valid held four cycles: every command used repeats harmlessly
  task automatic send(input logic [7:0] c, input logic ser, input logic hi,
                      input logic [1:0] a, input logic [7:0] d,
                      output logic wOk, output logic rOk);
    lfcs_prog_req_t idleReq;
    @(negedge clk);
    progReq = '{valid: 1'b1, serial: ser, cmd: c, selHigh: hi, addr: a, data: d};
    repeat (3) @(negedge clk);
    wOk = progWriteOk;
    rOk = progReadOk;
    @(negedge clk);
    // Released lines flip rather than keep stale values
    idleReq = ~progReq;
    idleReq.valid = 1'b0;
    progReq = idleReq;
    repeat (4) @(negedge clk);
  endtask
endmodule

/* File: test/lfcs_store_sva.sv */
// Port-level checker for the lock, fuse and configuration store
module lfcs_store_sva #(
  parameter int BOOT_START   = 12'hC00,
  parameter int ERASE_CYCLES = 16
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   progModeIn,
  input wire lfcs_pkg::lfcs_cpu_req_t cpuReq,
  input wire logic                   vectorsInBoot,
  input wire logic                   progBusy,
  input wire logic                   cpuStoreOk,
  input wire logic                   cpuLoadOk,
  input wire logic                   irqMask,
  input wire logic                   flashEraseReq,
  input wire logic                   eepromEraseReq,
  input wire logic [7:0]             protectionLockByte,
  input wire logic [7:0]             fuseHighActive,
  input wire logic [7:0]             fuseLowActive
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfcs_pkg::*;
  logic [15:0] busyCnt_r;
  logic [3:0]  modeAge_r;
  logic        modePrev_r;
  logic        aBoot;
  logic        pBoot;
  logic [7:0]  lk;
  assign aBoot = 32'(cpuReq.addr) >= BOOT_START;
  assign pBoot = 32'(cpuReq.pc) >= BOOT_START;
  assign lk = protectionLockByte;

  always_ff @(posedge clk) begin
    if (!rst_n || !progBusy) begin
      busyCnt_r <= 16'h0000;
    end else begin
      busyCnt_r <= busyCnt_r + 16'h0001;
    end
  end

  // Mode pin is synchronised, so latching lags the pin by a few cycles
  always_ff @(posedge clk) begin
    modePrev_r <= progModeIn;
    if (!rst_n) begin
      modeAge_r <= 4'hF;
    end else if (progModeIn != modePrev_r) begin
      modeAge_r <= 4'h0;
    end else if (modeAge_r != 4'hF) begin
      modeAge_r <= modeAge_r + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_eraseRun;
    progBusy ##1 progBusy;
  endsequence
  sequence s_eraseEnd;
    progBusy ##1 !progBusy;
  endsequence

  property p_lock_rise;
    (|(lk & ~$past(lk))) |-> $past(progBusy);
  endproperty
  property p_erase_hold;
    s_eraseRun |-> $stable(lk);
  endproperty
  property p_lock_restore;
    s_eraseEnd |-> lk == 8'hFF;
  endproperty
  property p_busy_len;
    $fell(progBusy) |-> 32'(busyCnt_r) == ERASE_CYCLES + 1;
  endproperty
  property p_erase_start;
    $rose(progBusy) |-> flashEraseReq ##1 flashEraseReq;
  endproperty
  property p_eeprom_keep;
    eepromEraseReq |-> progBusy && fuseHighActive[FH_EEPROM_PRES_BIT];
  endproperty
  property p_store_app;
    cpuReq.isStore && pBoot && !aBoot |-> cpuStoreOk == lk[LOCK_APP_WR_BIT];
  endproperty
  property p_store_boot;
    cpuReq.isStore && pBoot && aBoot |-> cpuStoreOk == lk[LOCK_BOOT_WR_BIT];
  endproperty
  property p_load_app;
    cpuReq.isLoad && pBoot && !aBoot |-> cpuLoadOk == lk[LOCK_APP_RD_BIT];
  endproperty
  property p_load_boot;
    cpuReq.isLoad && !pBoot && aBoot |-> cpuLoadOk == lk[LOCK_BOOT_RD_BIT];
  endproperty
  property p_irq_app;
    !pBoot |-> irqMask == (vectorsInBoot && !lk[LOCK_APP_RD_BIT]);
  endproperty
  property p_irq_boot;
    pBoot |-> irqMask == (!vectorsInBoot && !lk[LOCK_BOOT_RD_BIT]);
  endproperty
  property p_fuse_latch;
    $changed(fuseLowActive) |-> modeAge_r < 4'h8;
  endproperty

  a_lock_rise: assert property (p_lock_rise) else $error("lock bit rose");
  a_erase_hold: assert property (p_erase_hold) else $error("lock moved in erase");
  a_lock_restore: assert property (p_lock_restore) else $error("lock not FF");
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  a_erase_start: assert property (p_erase_start) else $error("no flash erase");
  a_eeprom_keep: assert property (p_eeprom_keep) else $error("eeprom erased");
  a_store_app: assert property (p_store_app) else $error("app store");
  a_store_boot: assert property (p_store_boot) else $error("boot store");
  a_load_app: assert property (p_load_app) else $error("app load");
  a_load_boot: assert property (p_load_boot) else $error("boot load");
  a_irq_app: assert property (p_irq_app) else $error("irq app");
  a_irq_boot: assert property (p_irq_boot) else $error("irq boot");
  a_fuse_latch: assert property (p_fuse_latch) else $error("fuse unlatched");
endmodule

bind lfcs_store lfcs_store_sva #(.BOOT_START(BOOT_START), .ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .clk, .rst_n, .progModeIn, .cpuReq, .vectorsInBoot, .progBusy, .cpuStoreOk, .cpuLoadOk,
  .irqMask, .flashEraseReq, .eepromEraseReq, .protectionLockByte, .fuseHighActive,
  .fuseLowActive);

/* File: test/lfcs_store_tb.sv */
// Self-checking bench for the lock, fuse and configuration store
module lfcs_store_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lfcs_pkg::*;
  localparam int ERASE_N = 12;
  localparam int BS      = 12'hC00;
  logic clk, rst_n, progModeIn, vectorsInBoot, cpuLockWrite, calLoad, wOk, rOk;
  logic progBusy, progWriteOk, progReadOk, cpuStoreOk, cpuLoadOk, irqMask;
  logic flashEraseReq, eepromEraseReq;
  logic [1:0] calSelect;
  logic [7:0] cpuLockData, progRdData, rcTrimRegister, protectionLockByte;
  logic [7:0] fuseHighActive, fuseLowActive, lockM, fhM, flM, fhAct, flAct, d;
  lfcs_prog_req_t progReq;
  lfcs_cpu_req_t  cpuReq;
  int errors, checkCount;
  // Identification and calibration defaults, values arbitrary
  logic [7:0] expId [7] = '{8'hA5, 8'h5A, 8'h3C, 8'h80, 8'h81, 8'h82, 8'h83};
  logic [7:0] modes [3] = '{8'hFF, 8'hFE, 8'hFC};
  logic [7:0] cmds [5] = '{CMD_WR_FLASH, CMD_WR_EEPROM, CMD_WR_FUSE, CMD_RD_FLASH,
                           CMD_RD_EEPROM};

  lfcs_store #(.ERASE_CYCLES(ERASE_N)) dut_u (.clk, .rst_n, .progModeIn, .progReq, .cpuReq,
    .vectorsInBoot, .cpuLockWrite, .cpuLockData, .calSelect, .calLoad, .progRdData,
    .progBusy, .progWriteOk, .progReadOk, .cpuStoreOk, .cpuLoadOk, .irqMask,
    .flashEraseReq, .eepromEraseReq, .rcTrimRegister, .protectionLockByte,
    .fuseHighActive, .fuseLowActive);
  lfcs_prog_model pm (.clk, .progWriteOk, .progReadOk, .progReq, .progModeIn);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic completeRun();
    if (errors == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
    checkCount++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmpBit(input string what, input logic e, input logic g);
    cmp8(what, {7'h00, e}, {7'h00, g});
  endtask

  task automatic checkFuses();
    cmp8("fuseH", {fhAct[7:4], fhM[3], fhAct[2:0]}, fuseHighActive);
    cmp8("fuseL", flAct, fuseLowActive);
  endtask

  task automatic cpuCheck();
    logic aB, pB;
    @(negedge clk);
    cpuReq = 26'($urandom);
    vectorsInBoot = 1'($urandom);
    #1;
    aB = 32'(cpuReq.addr) >= BS;
    pB = 32'(cpuReq.pc) >= BS;
    if (cpuReq.isStore && pB) cmpBit("store", aB ? lockM[4] : lockM[2], cpuStoreOk);
    if (cpuReq.isLoad) cmpBit("load", (aB == pB) | (aB ? lockM[5] : lockM[3]), cpuLoadOk);
    cmpBit("irq", pB ? !lockM[5] && !vectorsInBoot : !lockM[3] && vectorsInBoot, irqMask);
  endtask

  task automatic identLoop();
    for (int i = 0; i < 7; i++) begin
      pm.send(CMD_RD_IDENT, 1'(i), i > 2, 2'(i > 2 ? i - 3 : i), 8'h00, wOk, rOk);
      cmp8("ident", expId[i], progRdData);
    end
  endtask

  task automatic erase();
    int n;
    pm.send(CMD_CHIP_ERASE, 1'b0, 1'b0, 2'h0, 8'h00, wOk, rOk);
    cmpBit("busy", 1'b1, progBusy);
    cmpBit("flashErase", 1'b1, flashEraseReq);
    cmpBit("eeErase", fhM[3], eepromEraseReq);
    cmp8("lockHeld", lockM, protectionLockByte);
    for (n = 0; n < 50 && progBusy !== 1'b0; n++) @(negedge clk);
    if (n == 50) begin
      errors++;
      completeRun();
    end else begin
      lockM = 8'hFF;
      cmp8("lockErased", lockM, protectionLockByte);
      checkFuses();
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(57697));
    {rst_n, vectorsInBoot, cpuLockWrite, calLoad, calSelect} = '0;
    cpuReq = '0;
    cpuLockData = 8'hFF;
    errors = 0;
    checkCount = 0;
    lockM = 8'hFF;
    fhM = 8'hD9;
    flM = 8'hE1;
    fhAct = fhM;
    flAct = flM;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    cmp8("lock", lockM, protectionLockByte);
    checkFuses();
    cmp8("trim", expId[3], rcTrimRegister);
    for (int s = 0; s < 4; s++) begin
      repeat (16) cpuCheck();
      @(negedge clk);
      cpuLockWrite = 1'b1;
      cpuLockData = {2'b11, 4'($urandom), 2'b11};
      @(negedge clk);
      cpuLockWrite = 1'b0;
      lockM &= cpuLockData;
    end
    pm.setMode(1'b1);
    erase();
    // Fuses go in after erase, before any lock bit is programmed again
    d = 8'($urandom) & 8'hD7;
    pm.send(CMD_WR_FUSE, 1'b0, 1'b1, 2'h0, d, wOk, rOk);
    fhM = d;
    flM = 8'($urandom);
    pm.send(CMD_WR_FUSE, 1'b0, 1'b0, 2'h0, flM, wOk, rOk);
    pm.send(CMD_WR_FUSE, 1'b1, 1'b1, 2'h0, fhM ^ 8'h20, wOk, rOk);
    checkFuses();
    identLoop();
    @(negedge clk);
    calSelect = 2'($urandom);
    calLoad = 1'b1;
    @(negedge clk);
    calLoad = 1'b0;
    @(negedge clk);
    cmp8("trim", expId[3 + calSelect], rcTrimRegister);
    pm.setMode(1'b0);
    fhAct = fhM;
    flAct = flM;
    checkFuses();
    pm.setMode(1'b1);
    foreach (modes[m]) begin
      pm.send(CMD_WR_LOCK, 1'b0, 1'b0, 2'h0, modes[m], wOk, rOk);
      lockM &= modes[m];
      pm.send(CMD_RD_FUSELCK, 1'b0, 1'b0, 2'h2, 8'h00, wOk, rOk);
      cmp8("lockRd", lockM, progRdData);
      foreach (cmds[k]) begin
        pm.send(cmds[k], 1'(k), 1'b0, 2'h0, flM ^ 8'h01, wOk, rOk);
        if (cmds[k] == CMD_WR_FUSE) cmpBit("fuseWrOk", 1'b0, wOk);
        else if (cmds[k] > 8'h0F) cmpBit("progWrOk", &lockM[1:0], wOk);
        else cmpBit("progRdOk", |lockM[1:0], rOk);
        if (cmds[k] == CMD_WR_FUSE && lockM[0]) flM ^= 8'h01;
      end
      pm.send(CMD_RD_FUSELCK, 1'b0, 1'b0, 2'h0, 8'h00, wOk, rOk);
      cmp8("fuseLRd", flM, progRdData);
    end
    identLoop();
    erase();
    pm.setMode(1'b0);
    fhAct = fhM;
    flAct = flM;
    checkFuses();
    completeRun();
  end
endmodule
